/* core/adcc_defs.svh */
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// register byte offsets on the apb bus
`define ADCC_OFF_CS1      12'h000
`define ADCC_OFF_CS2      12'h004
`define ADCC_OFF_RES_HI   12'h008
`define ADCC_OFF_RES_LO   12'h00C
`define ADCC_OFF_CMP_HI   12'h010
`define ADCC_OFF_CMP_LO   12'h014
`define ADCC_OFF_CFG      12'h018

// control_status_one fields
`define ADCC_CS1_DONE     7
`define ADCC_CS1_CONT     5
`define ADCC_CHAN_OFF     5'h1F

// control_status_two fields
`define ADCC_CS2_ACTIVE   7
`define ADCC_CS2_TRIG     6
`define ADCC_CS2_CMPEN    5
`define ADCC_CS2_CMPGT    4

// config_reg fields
`define ADCC_CFG_LP       7
`define ADCC_CFG_DIV_HI   6
`define ADCC_CFG_DIV_LO   5
`define ADCC_CFG_LSMP     4
`define ADCC_CFG_MODE_HI  3
`define ADCC_CFG_MODE_LO  2
`define ADCC_CFG_CLK_HI   1
`define ADCC_CFG_CLK_LO   0
`define ADCC_MODE_8BIT    2'b00
`define ADCC_MODE_10BIT   2'b10

// reset values
`define ADCC_RST_CS1      8'h1F
`define ADCC_RST_ZERO     8'h00

`endif

/* core/adcc_pkg.sv */
package adcc_pkg;
   // apb request seen by the slave
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } adcc_apb_req_t;

   // start request towards the analog core
   typedef struct packed {
      logic       start;
      logic       low_power;
      logic       long_sample;
      logic       ten_bit;
      logic [4:0] channel;
   } adcc_core_req_t;

   // conversion engine state
   typedef enum logic [1:0] {
      ADCC_IDLE  = 2'b00,
      ADCC_START = 2'b01,
      ADCC_CONV  = 2'b10
   } adcc_state_t;
endpackage

/* core/adcc_ctrl.sv */
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "adcc_defs.svh"

module adcc_ctrl
   import adcc_pkg::*;
(
   // clock and reset
   input  wire logic           clk_sys,
   input  wire logic           rst,
   // apb slave
   input  wire adcc_apb_req_t  apb_req,
   output logic [31:0]         prdata,
   output logic                pready,
   output logic                pslverr,
   // trigger and clock sources
   input  wire logic           hardware_trigger_in,
   input  wire logic           alternate_clock,
   input  wire logic           async_converter_clock,
   // analog core
   output adcc_core_req_t      core_req,
   output logic                core_abort,
   input  wire logic           core_done,
   input  wire logic [9:0]     core_result,
   // converter clock enable towards the core
   output logic                converter_clock
);

   logic [7:0]  cs1_q;
   logic [7:0]  cs2_q;
   logic [7:0]  cfg_q;
   logic [1:0]  cmp_hi_q;
   logic [7:0]  cmp_lo_q;
   logic [9:0]  res_q;
   logic        lock_q;
   logic        done_flag_q;
   adcc_state_t state_q;
   logic [2:0]  trig_sync_q;
   logic [1:0]  done_sync_q;
   logic        done_seen_q;
   logic [1:0]  alt_sync_q;
   logic [1:0]  ack_sync_q;
   logic        alt_prev_q;
   logic        ack_prev_q;
   logic        half_q;
   logic [2:0]  div_cnt_q;
   logic        conv_clk_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;

   logic        setup;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic        wr_cs1;
   logic        rd_hi;
   logic        rd_lo;
   logic        ten_bit;
   logic        hw_trig;
   logic        start_req;
   logic        done_evt;
   logic        cmp_true;
   logic [9:0]  cmp_val;
   logic [9:0]  res_in;
   logic        src_tick;
   logic [2:0]  div_last;
   logic [4:0]  chan_sel;

   // apb decode; no wait state, answer in access phase
   // writes and read side effects happen at the setup edge only
   assign setup  = apb_req.psel & ~apb_req.penable;
   assign wr     = setup & apb_req.pwrite & mapped;
   assign rd     = setup & ~apb_req.pwrite & mapped;
   assign mapped = (apb_req.paddr == `ADCC_OFF_CS1) | (apb_req.paddr == `ADCC_OFF_CS2) |
                   (apb_req.paddr == `ADCC_OFF_RES_HI) | (apb_req.paddr == `ADCC_OFF_RES_LO) |
                   (apb_req.paddr == `ADCC_OFF_CMP_HI) | (apb_req.paddr == `ADCC_OFF_CMP_LO) |
                   (apb_req.paddr == `ADCC_OFF_CFG);
   assign wr_cs1 = wr & (apb_req.paddr == `ADCC_OFF_CS1);
   assign rd_hi  = rd & (apb_req.paddr == `ADCC_OFF_RES_HI);
   assign rd_lo  = rd & (apb_req.paddr == `ADCC_OFF_RES_LO);

   // mode decode, reserved codes treated as 8-bit
   // so the core never sees an undefined width
   assign ten_bit = ({cfg_q[`ADCC_CFG_MODE_HI], cfg_q[`ADCC_CFG_MODE_LO]}
                     == `ADCC_MODE_10BIT);

   // rising edge of synchronised hardware trigger
   assign hw_trig = trig_sync_q[1] & ~trig_sync_q[2];

   // channel as it stands after this cycle; a write counts at once
   assign chan_sel = wr_cs1 ? apb_req.pwdata[4:0] : cs1_q[4:0];

   // start sources; channel all ones disables the converter
   assign start_req = (chan_sel != `ADCC_CHAN_OFF) &&
                      ((cs2_q[`ADCC_CS2_TRIG] ? hw_trig : wr_cs1) ||
                       (cs1_q[`ADCC_CS1_CONT] && done_evt &&
                        !cs2_q[`ADCC_CS2_TRIG]));

   // completion event from synchronised core done
   assign done_evt = done_sync_q[1] & ~done_seen_q & (state_q == ADCC_CONV);

   // result masked to resolution
   // compare and result registers both see this masked value
   assign res_in  = ten_bit ? core_result : {2'b00, core_result[7:0]};
   // compare value: high bits only in 10-bit mode
   assign cmp_val = {ten_bit ? cmp_hi_q : 2'b00, cmp_lo_q};
   assign cmp_true = cs2_q[`ADCC_CS2_CMPGT] ? (res_in >= cmp_val)
                                             : (res_in < cmp_val);

   // register writes from software
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cs1_q    <= `ADCC_RST_CS1;
         cs2_q    <= `ADCC_RST_ZERO;
         cfg_q    <= `ADCC_RST_ZERO;
         cmp_hi_q <= 2'b00;
         cmp_lo_q <= `ADCC_RST_ZERO;
      end else if (wr) begin
         case (apb_req.paddr)
            `ADCC_OFF_CS1: begin
               // done flag lives in its own register; bit seven kept zero
               cs1_q <= {1'b0, apb_req.pwdata[6:0]};
            end
            `ADCC_OFF_CS2: begin
               // active bit is read only; low four bits kept zero
               cs2_q <= {1'b0, apb_req.pwdata[6:4], 4'h0};
            end
            `ADCC_OFF_CMP_HI: begin
               cmp_hi_q <= apb_req.pwdata[1:0];
            end
            `ADCC_OFF_CMP_LO: begin
               cmp_lo_q <= apb_req.pwdata[7:0];
            end
            `ADCC_OFF_CFG: begin
               cfg_q <= apb_req.pwdata[7:0];
            end
            default: begin
               cfg_q <= cfg_q;
            end
         endcase
      end
   end

   // hardware trigger: two flops, third stage only for edge detection
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         trig_sync_q <= 3'b000;
      end else begin
         trig_sync_q <= {trig_sync_q[1:0], hardware_trigger_in};
      end
   end

   // core done: two flops before any logic reads it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         done_sync_q <= 2'b00;
      end else begin
         done_sync_q <= {done_sync_q[0], core_done};
      end
   end

   // delayed copy, so a done level held over several cycles counts once
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         done_seen_q <= 1'b0;
      end else begin
         done_seen_q <= done_sync_q[1];
      end
   end

   // conversion engine
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q  <= ADCC_IDLE;
         core_req <= '0;
         core_abort <= 1'b0;
      end else begin
         core_req.start <= 1'b0;
         core_abort     <= 1'b0;
         case (state_q)
            ADCC_IDLE, ADCC_START, ADCC_CONV: begin
               if (start_req) begin
                  // abort a running conversion and restart in the same cycle; a finished one needs none
                  core_abort        <= (state_q != ADCC_IDLE) && !done_evt;
                  core_req.start    <= 1'b1;
                  core_req.low_power   <= cfg_q[`ADCC_CFG_LP];
                  core_req.long_sample <= cfg_q[`ADCC_CFG_LSMP];
                  core_req.ten_bit  <= ten_bit;
                  core_req.channel  <= chan_sel;
                  state_q           <= ADCC_START;
               end else if (wr_cs1 || done_evt) begin
                  // a write in the start cycle must still stop the core
                  core_abort <= (state_q != ADCC_IDLE) && wr_cs1;
                  state_q    <= ADCC_IDLE;
               end else if (state_q == ADCC_START) begin
                  state_q <= ADCC_CONV;
               end
            end
            default: begin
               state_q <= ADCC_IDLE;
            end
         endcase
      end
   end

   // result registers; a failed compare or a held lock keeps the old value
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         res_q <= 10'h000;
      end else if (done_evt && !(ten_bit && lock_q) &&
                   (!cs2_q[`ADCC_CS2_CMPEN] || cmp_true)) begin
         res_q <= res_in;
      end
   end

   // read interlock; only 10-bit mode holds it, results meanwhile
   // are dropped rather than queued
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lock_q <= 1'b0;
      end else if (rd_lo || !ten_bit) begin
         lock_q <= 1'b0;
      end else if (rd_hi) begin
         lock_q <= 1'b1;
      end
   end

   // done flag: set wins over clear
   // a completion in the same cycle as a clear must not be lost
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         done_flag_q <= 1'b0;
      end else if (done_evt && (!cs2_q[`ADCC_CS2_CMPEN] || cmp_true)) begin
         done_flag_q <= 1'b1;
      end else if (wr_cs1 || rd_lo) begin
         done_flag_q <= 1'b0;
      end
   end

   // alternate clock: two flops, then one more stage for its rising edge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         alt_sync_q <= 2'b00;
         alt_prev_q <= 1'b0;
      end else begin
         alt_sync_q <= {alt_sync_q[0], alternate_clock};
         alt_prev_q <= alt_sync_q[1];
      end
   end

   // async converter clock: same treatment, must run below half the bus clock
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_sync_q <= 2'b00;
         ack_prev_q <= 1'b0;
      end else begin
         ack_sync_q <= {ack_sync_q[0], async_converter_clock};
         ack_prev_q <= ack_sync_q[1];
      end
   end

   // bus clock halved, as an every-other-cycle tick
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         half_q <= 1'b0;
      end else begin
         half_q <= ~half_q;
      end
   end

   // source select ahead of the divider
   always_comb begin
      case ({cfg_q[`ADCC_CFG_CLK_HI], cfg_q[`ADCC_CFG_CLK_LO]})
         2'b00:   src_tick = 1'b1;
         2'b01:   src_tick = half_q;
         2'b10:   src_tick = alt_sync_q[1] & ~alt_prev_q;
         default: src_tick = ack_sync_q[1] & ~ack_prev_q;
      endcase
   end

   // divide ratio 1, 2, 4, 8
   always_comb begin
      case ({cfg_q[`ADCC_CFG_DIV_HI], cfg_q[`ADCC_CFG_DIV_LO]})
         2'b00:   div_last = 3'd0;
         2'b01:   div_last = 3'd1;
         2'b10:   div_last = 3'd3;
         default: div_last = 3'd7;
      endcase
   end

   // converter clock as a one-cycle tick per divided period
   // an enable on clk_sys, not a separate clock tree
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_cnt_q  <= 3'd0;
         conv_clk_q <= 1'b0;
      end else begin
         conv_clk_q <= 1'b0;
         if (src_tick) begin
            if (div_cnt_q >= div_last) begin
               div_cnt_q  <= 3'd0;
               conv_clk_q <= 1'b1;
            end else begin
               div_cnt_q <= div_cnt_q + 3'd1;
            end
         end
      end
   end

   // apb ready and error: every setup answered in the next cycle,
   // an unmapped address with an error and no side effect
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
      end
   end

   // apb read data, zero outside a read answer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prdata_q  <= 32'h0000_0000;
      end else begin
         prdata_q  <= 32'h0000_0000;
         if (rd) begin
            case (apb_req.paddr)
               `ADCC_OFF_CS1:    prdata_q[7:0] <= {done_flag_q, cs1_q[6:0]};
               `ADCC_OFF_CS2:    prdata_q[7:0] <= {state_q != ADCC_IDLE,
                                                   cs2_q[6:0]};
               `ADCC_OFF_RES_HI: prdata_q[7:0] <= {6'h00,
                                                   ten_bit ? res_q[9:8] : 2'b00};
               `ADCC_OFF_RES_LO: prdata_q[7:0] <= res_q[7:0];
               `ADCC_OFF_CMP_HI: prdata_q[7:0] <= {6'h00, cmp_hi_q};
               `ADCC_OFF_CMP_LO: prdata_q[7:0] <= cmp_lo_q;
               default:          prdata_q[7:0] <= cfg_q;
            endcase
         end
      end
   end

   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign converter_clock = conv_clk_q;

endmodule

/* verif/adcc_ctrl_props.sv */
`timescale 1ns/1ps
`include "adcc_defs.svh"
module adcc_ctrl_props
   import adcc_pkg::*;
(
   // clock and reset
   input wire logic           clk_sys,
   input wire logic           rst,
   // bus side
   input wire adcc_apb_req_t  apb_req,
   input wire logic [31:0]    prdata,
   input wire logic           pready,
   input wire logic           pslverr,
   // trigger and core side
   input wire logic           hardware_trigger_in,
   input wire adcc_core_req_t core_req,
   input wire logic           core_abort,
   input wire logic           core_done,
   input wire logic           converter_clock
);
   logic       setup_w;
   logic       cs1_w;
   logic       trig_q;
   logic       busy_q;
   logic [7:0] cfg_q;
   // setup phase and control_status_one write
   assign setup_w = apb_req.psel && !apb_req.penable;
   assign cs1_w   = setup_w && apb_req.pwrite && apb_req.paddr == `ADCC_OFF_CS1;
   // mirror of trigger and config writes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         trig_q <= 1'b0;
         cfg_q  <= 8'h00;
      end else if (setup_w && apb_req.pwrite) begin
         if (apb_req.paddr == `ADCC_OFF_CS2)
            trig_q <= apb_req.pwdata[`ADCC_CS2_TRIG];
         if (apb_req.paddr == `ADCC_OFF_CFG)
            cfg_q <= apb_req.pwdata[7:0];
      end
   end
   // conversion running at the core
   always_ff @(posedge clk_sys) begin
      if (rst)
         busy_q <= 1'b0;
      else if (core_req.start)
         busy_q <= 1'b1;
      else if (core_abort || core_done)
         busy_q <= 1'b0;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_start_pulse;
      core_req.start ##1 !core_req.start;
   endsequence
   sequence s_err_answer;
      pready && pslverr && prdata == 32'h0000_0000;
   endsequence
   a_ready_mapped: assert property (setup_w && apb_req.paddr <= `ADCC_OFF_CFG
      |=> pready && !pslverr) else $error("mapped access answer wrong");
   a_err_unmapped: assert property (setup_w && apb_req.paddr > `ADCC_OFF_CFG
      |=> s_err_answer) else $error("unmapped access not refused");
   a_sw_start: assert property (
      cs1_w && !trig_q && apb_req.pwdata[4:0] != `ADCC_CHAN_OFF |=> s_start_pulse)
      else $error("software start missing");
   a_req_channel: assert property (
      cs1_w && !trig_q && apb_req.pwdata[4:0] != `ADCC_CHAN_OFF
      |=> core_req.start && core_req.channel == $past(apb_req.pwdata[4:0]))
      else $error("core channel not the written one");
   a_no_start: assert property (
      cs1_w && (trig_q || apb_req.pwdata[4:0] == `ADCC_CHAN_OFF) |=> !core_req.start)
      else $error("unexpected start");
   a_abort_write: assert property (cs1_w && busy_q |-> ##[1:3] core_abort)
      else $error("running conversion not aborted");
   a_hw_start: assert property (
      trig_q && !busy_q && $rose(hardware_trigger_in) |-> ##[1:6] core_req.start)
      else $error("hardware start missing");
   a_req_config: assert property (core_req.start |->
      core_req.low_power == cfg_q[7] && core_req.long_sample == cfg_q[4]
      && core_req.ten_bit == (cfg_q[3:2] == `ADCC_MODE_10BIT))
      else $error("core request fields wrong");
   a_tick_div_one: assert property (
      (cfg_q[6:5] == 2'b00 && cfg_q[1:0] == 2'b00) [*4] |-> converter_clock)
      else $error("undivided tick missing");
endmodule

/* verif/adcc_core_model.sv */
`timescale 1ns/1ps
module adcc_core_model
   import adcc_pkg::*;
(
   // clock and reset
   input wire logic           clk_sys,
   input wire logic           rst,
   // request side
   input wire adcc_core_req_t core_req,
   input wire logic           core_abort,
   input wire logic [7:0]     delay_cyc,
   input wire logic [9:0]     value,
   // answer side
   output logic               core_done,
   output logic [9:0]         core_result
);
   logic [7:0] cnt_q;
   logic [2:0] hold_q;
   logic [9:0] res_q;
   logic       run_q;
   // countdown per conversion, abort drops it
   always_ff @(posedge clk_sys) begin
      if (rst)
         run_q <= 1'b0;
      else if (core_req.start) begin
         run_q <= 1'b1;
         cnt_q <= delay_cyc;
      end else if (core_abort || cnt_q == 8'h00)
         run_q <= 1'b0;
      else
         cnt_q <= cnt_q - 8'h01;
   end
   // done held four cycles with a stable result
   always_ff @(posedge clk_sys) begin
      if (rst)
         hold_q <= 3'h0;
      else if (run_q && cnt_q == 8'h00 && !core_abort && !core_req.start) begin
         hold_q <= 3'h4;
         res_q  <= value;
      end else if (hold_q != 3'h0)
         hold_q <= hold_q - 3'h1;
   end
   // result lines show junk outside the done window
   assign core_done   = hold_q != 3'h0;
   assign core_result = core_done ? res_q : ~res_q;
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
`include "adcc_defs.svh"
module tb_top
   import adcc_pkg::*;
;
   logic           clk_sys = 1'b0;
   logic           rst = 1'b1;
   logic           hw_trig = 1'b0;
   logic           alt_clk = 1'b0;
   logic           async_clk = 1'b0;
   adcc_apb_req_t  apb_req = '0;
   adcc_core_req_t core_req;
   logic [31:0]    prdata;
   logic [31:0]    rdat;
   logic           pready, pslverr, rerr, core_abort, core_done, converter_clock;
   logic [9:0]     core_result;
   logic [9:0]     val = 10'h000;
   logic [7:0]     dly = 8'h0A;
   logic [7:0]     last;
   int             failures = 0;
   int             checks = 0;
   int             cyc = 0;
   int             aborts = 0;
   // bus clock and two unrelated source clocks
   always #5 clk_sys = ~clk_sys;
   always #20.3 alt_clk = ~alt_clk;
   always #50.7 async_clk = ~async_clk;
   adcc_ctrl u_adcc_ctrl (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hardware_trigger_in(hw_trig), .alternate_clock(alt_clk),
      .async_converter_clock(async_clk), .core_req(core_req),
      .core_abort(core_abort), .core_done(core_done),
      .core_result(core_result), .converter_clock(converter_clock));
   adcc_core_model u_adcc_core_model (.clk_sys(clk_sys), .rst(rst),
      .core_req(core_req), .core_abort(core_abort), .delay_cyc(dly),
      .value(val), .core_done(core_done), .core_result(core_result));
   // cycle ceiling and abort counter
   always @(posedge clk_sys) begin
      cyc++;
      if (core_abort === 1'b1)
         aborts++;
      if (cyc == 20000) begin
         failures++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h00_0000, d}};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      apb_req <= '0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(rdat, {24'h00_0000, e});
   endtask
   task automatic conv(input logic [9:0] v, input logic [7:0] d, input logic [7:0] c);
      val <= v;
      dly <= d;
      wr(`ADCC_OFF_CS1, c);
   endtask
   task automatic wait_idle();
      do apb(1'b0, `ADCC_OFF_CS2, 8'h00); while (rdat[7] !== 1'b0);
   endtask
   task automatic cmp_case(input logic [7:0] cfg, input logic [7:0] cs2,
                           input logic [9:0] r, input logic t);
      wr(`ADCC_OFF_CFG, cfg);
      wr(`ADCC_OFF_CS2, cs2);
      conv(r, 8'h0A, 8'h03);
      wait_idle();
      rdc(`ADCC_OFF_CS1, {t, 7'h03});
      if (t)
         last = r[7:0];
      rdc(`ADCC_OFF_RES_LO, last);
   endtask
   task automatic t_regs();
      rdc(`ADCC_OFF_CS1, 8'h1F);
      rdc(`ADCC_OFF_CFG, 8'h00);
      wr(`ADCC_OFF_RES_LO, 8'hFF);
      rdc(`ADCC_OFF_RES_LO, 8'h00);
      wr(`ADCC_OFF_CS2, 8'h30);
      rdc(`ADCC_OFF_CS2, 8'h30);
      apb(1'b0, 12'h01C, 8'h00);
      chk({rdat[31:1], rerr}, 32'h0000_0001);
   endtask
   task automatic t_res();
      wr(`ADCC_OFF_CS2, 8'h00);
      wr(`ADCC_OFF_CFG, 8'h08);
      conv(10'h2A5, 8'h14, 8'h03);
      rdc(`ADCC_OFF_CS2, 8'h80);
      wait_idle();
      rdc(`ADCC_OFF_CS1, 8'h83);
      rdc(`ADCC_OFF_RES_HI, 8'h02);
      rdc(`ADCC_OFF_RES_LO, 8'hA5);
      rdc(`ADCC_OFF_CS1, 8'h03);
   endtask
   task automatic t_lock();
      conv(10'h155, 8'h0A, 8'h03);
      wait_idle();
      rdc(`ADCC_OFF_RES_HI, 8'h01);
      conv(10'h3FF, 8'h0A, 8'h03);
      rdc(`ADCC_OFF_CS1, 8'h03);
      wait_idle();
      rdc(`ADCC_OFF_RES_LO, 8'h55);
      conv(10'h0AA, 8'h0A, 8'h03);
      wait_idle();
      rdc(`ADCC_OFF_RES_HI, 8'h00);
      rdc(`ADCC_OFF_RES_LO, 8'hAA);
   endtask
   task automatic t_res8();
      wr(`ADCC_OFF_CFG, 8'h00);
      conv(10'h2C3, 8'h0A, 8'h03);
      wait_idle();
      rdc(`ADCC_OFF_RES_HI, 8'h00);
      conv(10'h03C, 8'h0A, 8'h03);
      wait_idle();
      rdc(`ADCC_OFF_RES_LO, 8'h3C);
   endtask
   task automatic t_cmp();
      wr(`ADCC_OFF_CMP_HI, 8'h02);
      wr(`ADCC_OFF_CMP_LO, 8'h00);
      cmp_case(8'h08, 8'h20, 10'h1FF, 1'b1);
      cmp_case(8'h08, 8'h20, 10'h200, 1'b0);
      cmp_case(8'h08, 8'h30, 10'h200, 1'b1);
      cmp_case(8'h08, 8'h30, 10'h1FF, 1'b0);
      cmp_case(8'h00, 8'h30, 10'h0C5, 1'b1);
      cmp_case(8'h00, 8'h20, 10'h010, 1'b0);
      cmp_case(8'h08, 8'h10, 10'h1FF, 1'b1);
   endtask
   task automatic t_abort();
      int n;
      wr(`ADCC_OFF_CS2, 8'h00);
      conv(10'h111, 8'h3C, 8'h03);
      n = aborts;
      conv(10'h122, 8'h0A, 8'h04);
      wait_idle();
      chk(aborts - n, 1);
      rdc(`ADCC_OFF_RES_LO, 8'h22);
      conv(10'h133, 8'h3C, 8'h03);
      wr(`ADCC_OFF_CS1, 8'h1F);
      rdc(`ADCC_OFF_CS2, 8'h00);
      chk(aborts - n, 2);
      conv(10'h1C3, 8'h0A, 8'h23);
      repeat (40) @(posedge clk_sys);
      rdc(`ADCC_OFF_CS2, 8'h80);
      rdc(`ADCC_OFF_CS1, 8'hA3);
      wr(`ADCC_OFF_CS1, 8'h1F);
      rdc(`ADCC_OFF_CS2, 8'h00);
      chk(aborts - n, 3);
   endtask
   task automatic t_hw();
      wr(`ADCC_OFF_CS2, 8'h40);
      conv(10'h0F0, 8'h0A, 8'h03);
      rdc(`ADCC_OFF_CS2, 8'h40);
      hw_trig <= 1'b1;
      repeat (6) @(posedge clk_sys);
      hw_trig <= 1'b0;
      rdc(`ADCC_OFF_CS2, 8'hC0);
      wait_idle();
      rdc(`ADCC_OFF_RES_LO, 8'hF0);
   endtask
   task automatic t_clk();
      logic [7:0] c [7] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h01, 8'h02, 8'h03};
      int         e [7] = '{64, 32, 16, 8, 32, 16, 6};
      int         n;
      for (int i = 0; i < 7; i++) begin
         wr(`ADCC_OFF_CFG, c[i]);
         repeat (16) @(posedge clk_sys);
         n = 0;
         repeat (64) @(posedge clk_sys) if (converter_clock === 1'b1) n++;
         chk(n >= e[i] - 2 && n <= e[i] + 2, 1);
      end
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // reset, then every scenario in turn
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      t_res();
      t_lock();
      t_res8();
      t_cmp();
      t_abort();
      t_hw();
      t_clk();
      final_report();
   end
endmodule
bind adcc_ctrl adcc_ctrl_props u_adcc_ctrl_props (.clk_sys(clk_sys), .rst(rst),
   .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .hardware_trigger_in(hardware_trigger_in), .core_req(core_req),
   .core_abort(core_abort), .core_done(core_done),
   .converter_clock(converter_clock));
